/* rtl/bit_delay_line.sv */
// clocked one-bit delay chain built from equal segments with a tap after each
module bit_delay_line #(
  parameter int unsigned SEG_LEN = 1024,
  parameter int unsigned SEGS    = 6
) (
  input  wire logic            i_core_clk,
  input  wire logic            i_reset,
  input  wire logic            i_shift,
  input  wire logic            i_bit,
  output logic [SEGS-1:0]      o_taps
);
  logic [SEG_LEN-1:0] seg      [SEGS];
  logic [SEG_LEN-1:0] next_seg [SEGS];

  genvar k;
  generate
    for (k = 0; k < SEGS; k++) begin : g_seg
      logic feed;
      if (k == 0) begin : g_head
        assign feed = i_bit;
      end else begin : g_link
        assign feed = seg[k-1][SEG_LEN-1];
      end
      always_comb begin
        next_seg[k] = seg[k];
        if (i_shift) begin
          next_seg[k] = {seg[k][SEG_LEN-2:0], feed};
        end
      end
      always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
          seg[k] <= '0;
        end else begin
          seg[k] <= next_seg[k];
        end
      end
      assign o_taps[k] = seg[k][SEG_LEN-1];
    end
  endgenerate
endmodule // bit_delay_line

/* rtl/phase_detector.sv */
// phase comparator with selectable one-bit delay line, averaging and readout
//
// What this block does
// RULE_01 - the comparison flop sets while the squared reference is 1 and clears while the squared measured signal is 1.
// RULE_02 - the flop's high time per cycle is proportional to the phase shift between the two inputs.
// RULE_03 - each squared input has a selectable inverter, adding 180 degrees so any slope pairing can be compared.
// RULE_04 - the delay path is six chained 1024-stage one-bit shift registers clocked at a variable rate carrying the reference.
// RULE_05 - a selector picks one of six chain outputs for the 0.5 to 3.0 metre settings.
// RULE_06 - fine trim of up to ten percent comes from varying the shift clock between 704 kHz and 633 kHz.
// RULE_07 - the reference leaves as one bit, passes the chain and returns as the delayed reference, unconverted.
// RULE_08 - with the delay unit connected, phase is taken between the delayed reference and the measured signal.
// RULE_09 - the outside party may supply an external shift clock for delays up to about 200 ms.
// RULE_10 - the shift clock need not reach 360 times the input rate; the jitter is removed by averaging.
// RULE_11 - the result is a three-digit value in degrees or radians over 0 to 360 or plus or minus 180 degrees.
// RULE_12 - full-scale calibration forces 360 degrees and zero calibration forces 0 degrees.
// RULE_13 - the averaging offers selectable longer time constants, down to a 2 Hz style setting.
// RULE_14 - in the plus or minus 180 range the result wraps from plus 180 to minus 180.
// RULE_15 - phase is high time over input period times 360, averaged over the selected time constant.
// RULE_16 - when set and clear of the comparison flop coincide, clear wins.
module phase_detector #(
  parameter int unsigned SEG_LEN    = phase_pkg::SEG_LEN,
  parameter int unsigned FIFO_DEPTH = phase_pkg::FIFO_DEPTH
) (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_reset,
  input  wire logic                       i_ref_sq,
  input  wire logic                       i_meas_sq,
  input  wire logic                       i_ext_shift_clk,
  input  wire logic                       i_hold,
  input  wire logic [3:0]                 i_addr,
  input  wire logic [31:0]                i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic [31:0]                     o_rdata,
  output logic                            o_compare,
  output logic signed [phase_pkg::PH_W-1:0] o_phase
);
  localparam int unsigned PH_W = phase_pkg::PH_W;
  localparam int unsigned CW   = phase_pkg::CNT_W;
  localparam int unsigned NW   = phase_pkg::NUM_W;
  localparam int unsigned AVW  = PH_W + phase_pkg::FRAC_W + 2;

  typedef enum logic [1:0] {DIV_IDLE, DIV_RUN, DIV_PUSH} div_state_t;

  // pin synchronisers: stage one is read only by stage two
  logic ref_s1, ref_s2, meas_s1, meas_s2, ext_s1, ext_s2, ext_d;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      {ref_s1, ref_s2, meas_s1, meas_s2, ext_s1, ext_s2, ext_d} <= '0;
    end else begin
      ref_s1  <= i_ref_sq;
      ref_s2  <= ref_s1;
      meas_s1 <= i_meas_sq;
      meas_s2 <= meas_s1;
      ext_s1  <= i_ext_shift_clk;
      ext_s2  <= ext_s1;
      ext_d   <= ext_s2;
    end
  end

  // register file
  phase_pkg::ctrl_t ctrl, next_ctrl;
  logic [7:0]       trim, next_trim;
  logic [31:0]      next_rdata;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;
  div_state_t       dstate, next_dstate;

  always_comb begin
    next_ctrl  = ctrl;
    next_trim  = trim;
    next_rdata = '0;
    if (i_wr && i_addr == phase_pkg::ADDR_CTRL) begin
      next_ctrl = phase_pkg::ctrl_t'(i_wdata[15:0]);
    end
    if (i_wr && i_addr == phase_pkg::ADDR_TRIM) begin
      // trim is held inside the documented shift clock span
      if (i_wdata[7:0] < phase_pkg::TRIM_MIN) begin // RULE_06
        next_trim = phase_pkg::TRIM_MIN;
      end else if (i_wdata[7:0] > phase_pkg::TRIM_MAX) begin
        next_trim = phase_pkg::TRIM_MAX;
      end else begin
        next_trim = i_wdata[7:0];
      end
    end
    if (i_rd) begin
      case (i_addr)
        phase_pkg::ADDR_CTRL:   next_rdata = {16'h0000, ctrl};
        phase_pkg::ADDR_TRIM:   next_rdata = {24'h000000, trim};
        phase_pkg::ADDR_PHASE:  next_rdata = {{(32-PH_W){o_phase[PH_W-1]}}, o_phase};
        phase_pkg::ADDR_STATUS: next_rdata = {24'h000000, 1'b0, dstate != DIV_IDLE,
                                              o_compare, 5'(fifo_level)};
        default:                next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ctrl    <= phase_pkg::ctrl_t'(phase_pkg::CTRL_RESET);
      trim    <= phase_pkg::TRIM_MIN;
      o_rdata <= '0;
    end else begin
      ctrl    <= next_ctrl;
      trim    <= next_trim;
      o_rdata <= next_rdata;
    end
  end

  // shift clock: trimmed internal divider or the external clock's rising edge
  logic [7:0] div_cnt, next_div_cnt;
  logic       shift_tick;
  always_comb begin
    next_div_cnt = (div_cnt == 8'h00) ? 8'(trim - 1'b1) : 8'(div_cnt - 1'b1); // RULE_06
    shift_tick   = ctrl.ext_clk ? (ext_s2 & ~ext_d) : (div_cnt == 8'h00); // RULE_09
  end
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // the reference travels as a single bit; no conversion on the way
  logic [phase_pkg::SEG_CNT-1:0] taps;
  bit_delay_line #(
    .SEG_LEN (SEG_LEN),
    .SEGS    (phase_pkg::SEG_CNT)
  ) u_delay (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_shift    (shift_tick),
    .i_bit      (ref_s2),
    .o_taps     (taps)
  ); // RULE_04 RULE_07

  logic [2:0] tap_idx;
  logic       ref_path, a_sq, b_sq;
  always_comb begin
    tap_idx  = (ctrl.tap_sel > phase_pkg::TAP_LAST) ? phase_pkg::TAP_LAST : ctrl.tap_sel; // RULE_05
    ref_path = ctrl.delay_en ? taps[tap_idx] : ref_s2; // RULE_08
    a_sq     = ref_path ^ ctrl.inv_ref; // RULE_03
    b_sq     = meas_s2 ^ ctrl.inv_meas; // RULE_03
  end

  // comparison flop and per-period counters, restarted on each reference rise
  logic          cmp_next, a_d, next_a_d, period_end;
  logic [CW-1:0] high_cnt, per_cnt, next_high_cnt, next_per_cnt;
  phase_pkg::period_t meas, next_meas;
  logic          meas_new, next_meas_new;
  always_comb begin
    cmp_next = o_compare;
    if (b_sq) begin
      cmp_next = 1'b0; // RULE_16 RULE_01
    end else if (a_sq) begin
      cmp_next = 1'b1; // RULE_01
    end
    next_a_d      = a_sq;
    period_end    = a_sq & ~a_d;
    next_meas     = meas;
    next_meas_new = 1'b0;
    next_high_cnt = (o_compare && high_cnt != '1) ? CW'(high_cnt + 1'b1) : high_cnt; // RULE_02
    next_per_cnt  = (per_cnt != '1) ? CW'(per_cnt + 1'b1) : per_cnt;
    if (period_end) begin
      // capture includes this cycle so the period counts every core cycle
      next_meas     = '{high_cnt: next_high_cnt, per_cnt: next_per_cnt};
      next_meas_new = (per_cnt != '0);
      next_high_cnt = '0;
      next_per_cnt  = '0;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_compare <= 1'b0;
      a_d       <= 1'b0;
      high_cnt  <= '0;
      per_cnt   <= '0;
      meas      <= '0;
      meas_new  <= 1'b0;
    end else begin
      o_compare <= cmp_next;
      a_d       <= next_a_d;
      high_cnt  <= next_high_cnt;
      per_cnt   <= next_per_cnt;
      meas      <= next_meas;
      meas_new  <= next_meas_new;
    end
  end

  // serial divider: high * scale / period; periods ending while busy are skipped,
  // which only thins the averaged sample stream
  logic [9:0]    scale;
  logic [NW-1:0] num, next_num;
  logic [CW:0]   rem, next_rem;
  logic [CW-1:0] den, next_den;
  logic [5:0]    bit_cnt, next_bit_cnt;
  logic [CW:0]   trial;
  logic          fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [PH_W-1:0] fifo_out;
  assign scale = ctrl.unit_rad ? phase_pkg::SCALE_RAD : phase_pkg::SCALE_DEG; // RULE_11
  always_comb begin
    next_dstate  = dstate;
    next_num     = num;
    next_rem     = rem;
    next_den     = den;
    next_bit_cnt = bit_cnt;
    trial        = {rem[CW-1:0], num[NW-1]};
    case (dstate)
      DIV_IDLE: begin
        if (meas_new) begin
          next_num     = NW'(meas.high_cnt * scale); // RULE_15
          next_den     = meas.per_cnt;
          next_rem     = '0;
          next_bit_cnt = 6'(NW);
          next_dstate  = DIV_RUN;
        end
      end
      DIV_RUN: begin
        next_num = {num[NW-2:0], 1'b0};
        next_rem = trial;
        if (trial >= {1'b0, den}) begin
          next_rem    = (CW+1)'(trial - {1'b0, den});
          next_num[0] = 1'b1;
        end
        next_bit_cnt = 6'(bit_cnt - 1'b1);
        if (bit_cnt == 6'h01) begin
          next_dstate = DIV_PUSH;
        end
      end
      DIV_PUSH: begin
        if (fifo_in_ready) begin
          next_dstate = DIV_IDLE;
        end
      end
      default: next_dstate = DIV_IDLE;
    endcase
  end
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      dstate  <= DIV_IDLE;
      num     <= '0;
      rem     <= '0;
      den     <= '0;
      bit_cnt <= '0;
    end else begin
      dstate  <= next_dstate;
      num     <= next_num;
      rem     <= next_rem;
      den     <= next_den;
      bit_cnt <= next_bit_cnt;
    end
  end

  sample_fifo #(
    .WIDTH (PH_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk  (i_core_clk),
    .i_reset     (i_reset),
    .i_in_valid  (dstate == DIV_PUSH),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (PH_W'(num[9:0])),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (~i_hold),
    .o_out_data  (fifo_out),
    .o_level     (fifo_level)
  );
  assign fifo_pop = fifo_out_valid & ~i_hold;

  // first-order average: larger tc_sel gives the longer time constants
  logic signed [AVW-1:0] avg, next_avg, diff;
  logic [9:0]            avg_int, half, full;
  logic signed [PH_W-1:0] next_phase;
  always_comb begin
    diff     = $signed({2'b00, fifo_out, phase_pkg::FRAC_W'(0)}) - avg;
    next_avg = avg;
    if (fifo_pop) begin
      next_avg = avg + (diff >>> ctrl.tc_sel); // RULE_13 RULE_10 RULE_15
    end
    avg_int    = 10'(avg >>> phase_pkg::FRAC_W);
    half       = ctrl.unit_rad ? phase_pkg::HALF_RAD : phase_pkg::HALF_DEG;
    full       = scale;
    next_phase = $signed({1'b0, avg_int});
    if (ctrl.range_pm && avg_int > half) begin
      next_phase = $signed({1'b0, avg_int}) - $signed({1'b0, full}); // RULE_14
    end
    if (ctrl.cal_full) begin
      next_phase = $signed({1'b0, full}); // RULE_12
    end else if (ctrl.cal_zero) begin
      next_phase = '0; // RULE_12
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      avg     <= '0;
      o_phase <= '0;
    end else begin
      avg     <= next_avg;
      o_phase <= next_phase;
    end
  end
endmodule // phase_detector

/* rtl/phase_pkg.sv */
// shared constants, register map and control layout of the phase detector
package phase_pkg;
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned SHIFT_HZ_HI = 704_000;
  localparam int unsigned SHIFT_HZ_LO = 633_000;
  localparam logic [7:0]  TRIM_MIN    = 8'(CLK_HZ / SHIFT_HZ_HI);
  localparam logic [7:0]  TRIM_MAX    = 8'(CLK_HZ / SHIFT_HZ_LO);

  localparam int unsigned SEG_LEN     = 1024;
  localparam int unsigned SEG_CNT     = 6;
  localparam logic [2:0]  TAP_LAST    = 3'h5;

  localparam int unsigned CNT_W       = 24;
  localparam int unsigned NUM_W       = 34;
  localparam int unsigned PH_W        = 11;
  localparam int unsigned FRAC_W      = 8;
  localparam int unsigned FIFO_DEPTH  = 16;

  localparam logic [9:0]  SCALE_DEG   = 10'h168;
  localparam logic [9:0]  SCALE_RAD   = 10'h274;
  localparam logic [9:0]  HALF_DEG    = 10'h0B4;
  localparam logic [9:0]  HALF_RAD    = 10'h13A;

  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_TRIM   = 4'h4;
  localparam logic [3:0]  ADDR_PHASE  = 4'h8;
  localparam logic [3:0]  ADDR_STATUS = 4'hC;

  localparam logic [15:0] CTRL_RESET  = 16'h0000;

  typedef struct packed {
    logic [2:0] tc_sel;
    logic       cal_zero;
    logic       cal_full;
    logic       unit_rad;
    logic       range_pm;
    logic       ext_clk;
    logic       tap_res;
    logic [2:0] tap_sel;
    logic       delay_en;
    logic       inv_meas;
    logic       inv_ref;
    logic       spare;
  } ctrl_t;

  typedef struct packed {
    logic [CNT_W-1:0] high_cnt;
    logic [CNT_W-1:0] per_cnt;
  } period_t;
endpackage

/* rtl/sample_fifo.sv */
// synchronous valid/ready fifo with parameterised width and depth
module sample_fifo #(
  parameter int unsigned WIDTH = 11,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_reset,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data,
  output logic [$clog2(DEPTH):0] o_level
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign o_out_valid = (count != '0);
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;
  assign o_out_data  = mem[rd_ptr];
  assign o_level     = count;

  always_comb begin
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage carries no reset: only entries below count are ever read
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end
endmodule // sample_fifo

/* sim/phase_detector_properties.sv */
// checker watching the phase detector ports
module phase_detector_checker #(
  parameter int unsigned SEG_LEN    = 1024,
  parameter int unsigned FIFO_DEPTH = 16
) (
  input wire logic                           i_core_clk,
  input wire logic                           i_reset,
  input wire logic                           i_ref_sq,
  input wire logic                           i_meas_sq,
  input wire logic                           i_ext_shift_clk,
  input wire logic                           i_hold,
  input wire logic [3:0]                     i_addr,
  input wire logic [31:0]                    i_wdata,
  input wire logic                           i_wr,
  input wire logic                           i_rd,
  input wire logic [31:0]                    o_rdata,
  input wire logic                           o_compare,
  input wire logic signed [phase_pkg::PH_W-1:0] o_phase
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  phase_pkg::ctrl_t ctrl;
  phase_pkg::ctrl_t next_ctrl;
  // shadow of the control word so pin relations can follow the inverters
  always_comb begin
    next_ctrl = ctrl;
    if (i_wr && i_addr == phase_pkg::ADDR_CTRL) next_ctrl = i_wdata[15:0];
  end
  always_ff @(posedge i_core_clk) ctrl <= i_reset ? '0 : next_ctrl;
  sequence s_rd(logic [3:0] a);
    i_rd && i_addr == a;
  endsequence
  sequence s_clear_held;
    (i_meas_sq ^ ctrl.inv_meas)[*4];
  endsequence
  sequence s_set_held;
    ((i_ref_sq ^ ctrl.inv_ref) && !(i_meas_sq ^ ctrl.inv_meas) && !ctrl.delay_en)[*4];
  endsequence
  chk_clear_wins: assert property (s_clear_held |=> !o_compare)
    else $error("compare high while measured input active");
  chk_set_on_ref: assert property (s_set_held |=> o_compare)
    else $error("compare low while reference alone active");
  chk_cal_full: assert property (
    (ctrl.cal_full && !ctrl.range_pm && !ctrl.unit_rad)[*2]
    |-> o_phase == $signed({1'b0, phase_pkg::SCALE_DEG}))
    else $error("full scale calibration not forced");
  chk_cal_zero: assert property ((ctrl.cal_zero && !ctrl.cal_full)[*2] |-> o_phase == 11'sh0)
    else $error("zero calibration not forced");
  chk_range_full: assert property (
    (!ctrl.range_pm)[*3] |-> o_phase >= 11'sh0 && o_phase <= $signed({1'b0, phase_pkg::SCALE_RAD}))
    else $error("phase outside full range");
  chk_range_wrap: assert property (
    (ctrl.range_pm && !ctrl.cal_full && !ctrl.cal_zero)[*3]
    |-> o_phase >= -$signed({1'b0, phase_pkg::HALF_RAD})
        && o_phase <= $signed({1'b0, phase_pkg::HALF_RAD}))
    else $error("phase outside signed range");
  chk_trim_range: assert property (s_rd(phase_pkg::ADDR_TRIM)
    |=> o_rdata >= 32'(phase_pkg::TRIM_MIN) && o_rdata <= 32'(phase_pkg::TRIM_MAX))
    else $error("trim outside shift clock range");
  chk_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data outside read cycle");
  chk_unmapped_zero: assert property (i_rd && i_addr[1:0] != 2'h0 |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_phase_read: assert property (s_rd(phase_pkg::ADDR_PHASE)
    |=> o_rdata == 32'($signed($past(o_phase))))
    else $error("phase register differs from output");
  chk_status_read: assert property (s_rd(phase_pkg::ADDR_STATUS)
    |=> o_rdata[4:0] <= 5'(FIFO_DEPTH) && o_rdata[5] == $past(o_compare) && o_rdata[31:7] == 25'h0)
    else $error("status word malformed");
endmodule // phase_detector_checker

bind phase_detector phase_detector_checker #(.SEG_LEN(SEG_LEN), .FIFO_DEPTH(FIFO_DEPTH)) chk (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_ref_sq(i_ref_sq), .i_meas_sq(i_meas_sq),
  .i_ext_shift_clk(i_ext_shift_clk), .i_hold(i_hold), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_compare(o_compare), .o_phase(o_phase));

/* sim/phase_detector_tb_top.sv */
// self-checking bench for the phase detector
module phase_detector_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 720;
  logic               clk, rst, hold, wr, rd, ref_sq, meas_sq, sclk, cmp;
  logic [3:0]         addr;
  logic [31:0]        wdata, rdata;
  logic signed [10:0] phase;
  logic [15:0]        ph_cyc, ref_hi, meas_hi;
  int                 bad_count, num_checks;
  phase_pkg::ctrl_t   c;
  phase_source #(.P(P)) src (.i_core_clk(clk), .i_phase_cyc(ph_cyc), .i_ref_hi(ref_hi),
    .i_meas_hi(meas_hi), .o_ref_sq(ref_sq), .o_meas_sq(meas_sq), .o_shift_clk(sclk));
  // short segments keep the run brief; delays scale from SEG_LEN = 8
  phase_detector #(.SEG_LEN(8), .FIFO_DEPTH(16)) dut (.i_core_clk(clk), .i_reset(rst),
    .i_ref_sq(ref_sq), .i_meas_sq(meas_sq), .i_ext_shift_clk(sclk), .i_hold(hold),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_compare(cmp), .o_phase(phase));
  task automatic results;
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(string name, logic signed [31:0] seen, logic signed [31:0] exp, int tol);
    logic signed [31:0] d;
    d = seen - exp;
    num_checks++;
    if (!((d <= tol && d >= -tol) === 1'b1)) begin
      bad_count++;
      $display("unexpected %s expected %0d seen %0d", name, exp, seen);
    end
  endtask
  task automatic wr_reg(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask
  task automatic set_ctrl;
    wr_reg(phase_pkg::ADDR_CTRL, 32'(c));
  endtask
  task automatic settle_read(int exp, int tol);
    logic [31:0] d;
    repeat (6 * P) @(posedge clk);
    @(negedge clk);
    check("phase port", phase, exp, tol);
    rd_reg(phase_pkg::ADDR_PHASE, d);
    check("phase", d, exp, tol);
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [7:0]  tw[3] = '{8'h05, 8'hFF, 8'h96};
    logic [7:0]  te[3] = '{8'h8E, 8'h9D, 8'h96};
    rd_reg(phase_pkg::ADDR_TRIM, d);
    check("trim reset", d, 32'h8E, 0);
    rd_reg(phase_pkg::ADDR_CTRL, d);
    check("ctrl reset", d, 32'h0, 0);
    for (int i = 0; i < 3; i++) begin
      wr_reg(phase_pkg::ADDR_TRIM, 32'(tw[i]));
      rd_reg(phase_pkg::ADDR_TRIM, d);
      check("trim clamp", d, 32'(te[i]), 0);
    end
    wr_reg(phase_pkg::ADDR_CTRL, 32'h0706);
    rd_reg(phase_pkg::ADDR_CTRL, d);
    check("ctrl readback", d, 32'h0706, 0);
    wr_reg(4'h6, 32'hFFFF);
    rd_reg(4'h6, d);
    check("unmapped", d, 32'h0, 0);
  endtask
  task automatic t_compare;
    int phi[3] = '{45, 90, 270};
    int n;
    c = '0;
    set_ctrl();
    ref_hi <= 16'h14;
    meas_hi <= 16'h14;
    foreach (phi[i]) begin
      ph_cyc <= 16'(2 * phi[i]);
      repeat (2 * P) @(posedge clk);
      n = 0;
      repeat (P) @(negedge clk) n += int'(cmp);
      check("compare high time", n, 2 * phi[i], 4);
      settle_read(phi[i], 3);
    end
    c.range_pm = 1'b1;
    set_ctrl();
    settle_read(-90, 3);
    c = '0;
    c.unit_rad = 1'b1;
    ph_cyc <= 16'h00B4;
    set_ctrl();
    settle_read(157, 3);
    // slowest averaging moves only a few units off the radian value in six periods
    c.unit_rad = 1'b0;
    c.tc_sel = 3'h7;
    set_ctrl();
    settle_read(153, 3);
  endtask
  task automatic t_invert;
    int exp[4] = '{180, 45, 45, 180};
    ref_hi <= 16'h0168;
    meas_hi <= 16'h0168;
    ph_cyc <= 16'h01C2;
    for (int k = 0; k < 4; k++) begin
      c = '0;
      c.inv_ref = k[0];
      c.inv_meas = k[1];
      set_ctrl();
      settle_read(exp[k], 3);
    end
  endtask
  task automatic t_cal;
    logic [31:0] d;
    logic [1:0]  m[3] = '{2'b01, 2'b11, 2'b10};
    int          exp[3] = '{360, 360, 0};
    for (int i = 0; i < 3; i++) begin
      c = '0;
      c.cal_full = m[i][0];
      c.cal_zero = m[i][1];
      set_ctrl();
      repeat (4) @(posedge clk);
      rd_reg(phase_pkg::ADDR_PHASE, d);
      check("calibration", d, exp[i], 0);
    end
  endtask
  task automatic t_delay;
    int tap[4] = '{0, 2, 5, 7};
    int e;
    ref_hi <= 16'h0048;
    meas_hi <= 16'h0014;
    ph_cyc <= 16'h0;
    foreach (tap[i]) begin
      c = '0;
      c.delay_en = 1'b1;
      c.ext_clk = 1'b1;
      c.tap_sel = 3'(tap[i]);
      set_ctrl();
      e = (tap[i] > 5) ? 5 : tap[i];
      // delayed reference trails by 8 stages per tap at 10 cycles per shift
      settle_read((P - 80 * (e + 1)) / 2, 8);
    end
  endtask
  task automatic t_fifo;
    logic [31:0] d;
    int          i;
    c = '0;
    set_ctrl();
    hold <= 1'b1;
    repeat (18 * P) @(posedge clk);
    rd_reg(phase_pkg::ADDR_STATUS, d);
    check("fifo full level", d[4:0], 16, 0);
    hold <= 1'b0;
    i = 0;
    do begin
      rd_reg(phase_pkg::ADDR_STATUS, d);
      i++;
    end while (d[4:0] !== 5'h0 && i < 1000);
    check("fifo drained level", d[4:0], 0, 0);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    hold = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    ph_cyc = 16'h0;
    ref_hi = 16'h14;
    meas_hi = 16'h14;
    bad_count = 0;
    num_checks = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_cal();
    t_compare();
    t_invert();
    t_delay();
    t_fifo();
    results();
  end
endmodule // phase_detector_tb_top

/* sim/phase_source.sv */
// far side model: squared reference and measured signals plus external shift clock
module phase_source #(
  parameter int P = 720
) (
  input  wire logic        i_core_clk,
  input  wire logic [15:0] i_phase_cyc,
  input  wire logic [15:0] i_ref_hi,
  input  wire logic [15:0] i_meas_hi,
  output logic             o_ref_sq,
  output logic             o_meas_sq,
  output logic             o_shift_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  int sc  = 0;
  always @(posedge i_core_clk) begin
    cnt <= (cnt + 1) % P;
    sc <= (sc + 1) % 10;
    o_ref_sq <= cnt < int'(i_ref_hi);
    o_meas_sq <= ((cnt + P - int'(i_phase_cyc)) % P) < int'(i_meas_hi);
    // far below 360 times the signal rate; the averager absorbs the jitter
    o_shift_clk <= sc < 5;
  end
endmodule // phase_source
